/* File: core/switch_mac_lookup_engine.v */
// MII-side MAC, learning table and frame filter for the third switch port.
`default_nettype none
`include "switch_mac_defs.vh"
module switch_mac_lookup_engine (
    input wire CLK,
    input wire RESET,
    input wire REG_WRITE,
    input wire REG_READ,
    input wire [6:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    input wire MAC_MODE,
    input wire SPEED_100,
    input wire HALF_DUPLEX,
    input wire HALF_DUPLEX_LOSSLESS_STRAP,
    input wire STORM_PORT_EN,
    input wire STORM_MCAST_EN,
    input wire MII_RX_CLK,
    input wire MII_RX_DV,
    input wire [3:0] MII_RXD,
    input wire MII_RX_ERR,
    input wire MII_COLLISION,
    input wire MII_TX_CLK,
    output reg MII_TRANSMIT_ENABLE,
    output reg [3:0] MII_TXD,
    output wire MII_TRANSMIT_ERROR,
    output reg MII_CARRIER_SENSE,
    input wire FRAME_END,
    input wire FRAME_GOOD,
    input wire FRAME_IS_PAUSE,
    input wire FRAME_IS_BCAST,
    input wire FRAME_IS_MCAST,
    input wire FRAME_VLAN_TAGGED,
    input wire [10:0] FRAME_BYTES,
    input wire [15:0] FRAME_PAUSE_QUANTA,
    input wire [47:0] FRAME_SA,
    input wire [47:0] FRAME_DA,
    input wire [1:0] FRAME_PORT,
    input wire [2:0] STATIC_PORTS,
    input wire STATIC_HIT,
    input wire [2:0] VLAN_MEMBERS,
    input wire [2:0] TREE_MASK,
    input wire [2:0] MIRROR_PORTS,
    input wire [2:0] PORT_VLAN_MASK,
    input wire RESOURCE_LOW,
    input wire RESOURCE_OK,
    input wire RX_QUEUE_FULL,
    input wire BUF_ALLOC,
    input wire BUF_FREE,
    output reg BUF_GRANT,
    input wire TX_PENDING,
    input wire TX_START,
    input wire TX_DONE,
    output reg [2:0] FIRST_STAGE_PORT_SET,
    output reg [2:0] FINAL_EGRESS_PORT_SET,
    output reg FORWARD,
    output reg SEND_XOFF,
    output reg SEND_XON,
    output reg TX_HOLD,
    output reg TX_DROP,
    output reg [7:0] USED_BUFFERS
);
// -----------------------------------------------------------------
// Register file
// -----------------------------------------------------------------
reg [7:0] share_ctrl;
reg [7:0] aging_ctrl;
reg [7:0] size_ctrl;
reg [7:0] storm_high;
reg [7:0] storm_low;
reg strap_seen;
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        share_ctrl <= `RST_BUF_SHARE;
        aging_ctrl <= `RST_AGING_BACKOFF;
        size_ctrl <= `RST_SIZE_COLL;
        storm_high <= `RST_STORM;
        storm_low <= `RST_STORM;
        strap_seen <= 1'b0;
    end else if (!strap_seen) begin
        strap_seen <= 1'b1;
        aging_ctrl[`BIT_AGGR_BACKOFF] <= HALF_DUPLEX_LOSSLESS_STRAP;
        size_ctrl[`BIT_NO_EXC_DROP] <= HALF_DUPLEX_LOSSLESS_STRAP;
    end else if (REG_WRITE) begin
        case (REG_ADDR)
            `REG_BUF_SHARE: share_ctrl <= REG_WDATA;
            `REG_AGING_BACKOFF: aging_ctrl <= REG_WDATA;
            `REG_SIZE_COLL: size_ctrl <= REG_WDATA;
            `REG_STORM_HIGH: storm_high <= REG_WDATA;
            `REG_STORM_LOW: storm_low <= REG_WDATA;
            default: share_ctrl <= share_ctrl;
        endcase
    end
end
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        REG_RDATA <= 8'h00;
    end else if (REG_READ) begin
        case (REG_ADDR)
            `REG_BUF_SHARE: REG_RDATA <= share_ctrl;
            `REG_AGING_BACKOFF: REG_RDATA <= aging_ctrl;
            `REG_SIZE_COLL: REG_RDATA <= size_ctrl;
            `REG_STORM_HIGH: REG_RDATA <= storm_high;
            `REG_STORM_LOW: REG_RDATA <= storm_low;
            default: REG_RDATA <= 8'h00;
        endcase
    end
end
// -----------------------------------------------------------------
// Pin synchronisers and link clock edges
// -----------------------------------------------------------------
reg [1:0] s_rxc, s_txc, s_dv, s_err, s_col;
reg [3:0] s_rxd_a, s_rxd_b;
reg rxc_d, txc_d;
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        s_rxc <= 2'b00;
        s_txc <= 2'b00;
        s_dv <= 2'b00;
        s_err <= 2'b00;
        s_col <= 2'b00;
        s_rxd_a <= 4'h0;
        s_rxd_b <= 4'h0;
        rxc_d <= 1'b0;
        txc_d <= 1'b0;
    end else begin
        s_rxc <= {s_rxc[0], MII_RX_CLK};
        s_txc <= {s_txc[0], MII_TX_CLK};
        s_dv <= {s_dv[0], MII_RX_DV};
        s_err <= {s_err[0], MII_RX_ERR & ~MAC_MODE};
        s_col <= {s_col[0], MII_COLLISION};
        s_rxd_a <= MII_RXD;
        s_rxd_b <= s_rxd_a;
        rxc_d <= s_rxc[1];
        txc_d <= s_txc[1];
    end
end
// In MAC mode the device faces a PHY, so its transmit timing follows the
// PHY-supplied transmit clock; in PHY mode it follows the receive clock.
wire tx_edge = MAC_MODE ? (s_txc[1] & ~txc_d) : (s_rxc[1] & ~rxc_d);
assign MII_TRANSMIT_ERROR = 1'b0;
wire col_now = s_col[1] & HALF_DUPLEX;
// -----------------------------------------------------------------
// Frame filter and forwarding
// -----------------------------------------------------------------
wire [10:0] max_len = (size_ctrl[`BIT_LONG_FRAME] ? 11'd`MAX_FRAME_LONG :
    11'd`MAX_FRAME_STD) + (FRAME_VLAN_TAGGED ? 11'd`VLAN_TAG_BYTES : 11'd0);
wire size_ok = (FRAME_BYTES >= 11'd`MIN_FRAME) &&
    (FRAME_BYTES <= max_len);
wire good = FRAME_GOOD & size_ok & ~s_err[1];
reg [47:0] tab_mac [0:`TABLE_ENTRIES-1];
reg [1:0] tab_port [0:`TABLE_ENTRIES-1];
reg [7:0] tab_stamp [0:`TABLE_ENTRIES-1];
reg [`TABLE_ENTRIES-1:0] tab_valid;
reg [9:0] sa_idx, da_idx, free_idx;
reg sa_hit, da_hit, have_free;
integer i;
always @* begin
    sa_idx = 10'd0;
    da_idx = 10'd0;
    free_idx = 10'h3ff;
    sa_hit = 1'b0;
    da_hit = 1'b0;
    have_free = 1'b0;
    for (i = `TABLE_ENTRIES - 1; i >= 0; i = i - 1) begin
        if (tab_valid[i] && tab_mac[i] == FRAME_SA) begin
            sa_hit = 1'b1;
            sa_idx = i[9:0];
        end
        if (tab_valid[i] && tab_mac[i] == FRAME_DA) begin
            da_hit = 1'b1;
            da_idx = i[9:0];
        end
        if (!tab_valid[i]) begin
            have_free = 1'b1;
            free_idx = i[9:0];
        end
    end
end
reg [7:0] now_stamp;
reg [31:0] sec_cnt;
reg [9:0] age_idx;
wire [7:0] age = now_stamp - tab_stamp[age_idx];
wire age_out = aging_ctrl[`BIT_AGING_EN] && tab_valid[age_idx] &&
    age >= 8'd`AGING_SECONDS;
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        sec_cnt <= 32'h0000_0000;
        now_stamp <= 8'h00;
        age_idx <= 10'd0;
    end else begin
        age_idx <= age_idx + 10'd1;
        if (sec_cnt == `TICK_CYCLES - 1) begin
            sec_cnt <= 32'h0000_0000;
            now_stamp <= now_stamp + 8'h01;
        end else begin
            sec_cnt <= sec_cnt + 32'h0000_0001;
        end
    end
end
always @(posedge CLK) begin
    if (FRAME_END && good && !FRAME_IS_PAUSE) begin
        if (sa_hit) begin
            tab_port[sa_idx] <= FRAME_PORT;
            tab_stamp[sa_idx] <= now_stamp;
        end else begin
            tab_mac[free_idx] <= FRAME_SA;
            tab_port[free_idx] <= FRAME_PORT;
            tab_stamp[free_idx] <= now_stamp;
        end
    end
end
wire learn = FRAME_END && good && !FRAME_IS_PAUSE && !sa_hit;
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        tab_valid <= {`TABLE_ENTRIES{1'b0}};
    end else begin
        if (age_out && !(learn && free_idx == age_idx))
            tab_valid[age_idx] <= 1'b0;
        if (learn)
            tab_valid[free_idx] <= 1'b1;
    end
end
wire [2:0] ingress = 3'b001 << FRAME_PORT;
reg [2:0] next_first;
always @* begin
    if (STATIC_HIT)
        next_first = STATIC_PORTS;
    else if (da_hit && !FRAME_IS_BCAST && !FRAME_IS_MCAST)
        next_first = 3'b001 << tab_port[da_idx];
    else
        next_first = VLAN_MEMBERS & ~ingress;
end
wire [2:0] next_final = ((next_first & TREE_MASK & PORT_VLAN_MASK) |
    MIRROR_PORTS) & ~ingress;
wire is_local = (next_first == ingress);
// -----------------------------------------------------------------
// Storm control
// -----------------------------------------------------------------
reg [31:0] storm_tmr;
reg [15:0] storm_frames;
wire storm_kind = FRAME_IS_BCAST | (STORM_MCAST_EN & FRAME_IS_MCAST);
wire storm_over = STORM_PORT_EN && storm_kind &&
    storm_frames >= {storm_high, storm_low};
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        storm_tmr <= 32'h0000_0000;
        storm_frames <= 16'h0000;
    end else if (storm_tmr >= (SPEED_100 ? `STORM_CYC_100 - 1 :
        `STORM_CYC_10 - 1)) begin
        storm_tmr <= 32'h0000_0000;
        storm_frames <= 16'h0000;
    end else begin
        storm_tmr <= storm_tmr + 32'h0000_0001;
        if (FRAME_END && storm_kind && !storm_over)
            storm_frames <= storm_frames + 16'h0001;
    end
end
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        FIRST_STAGE_PORT_SET <= 3'b000;
        FINAL_EGRESS_PORT_SET <= 3'b000;
        FORWARD <= 1'b0;
    end else begin
        FORWARD <= FRAME_END && good && !FRAME_IS_PAUSE && !is_local &&
            !storm_over;
        if (FRAME_END) begin
            FIRST_STAGE_PORT_SET <= next_first;
            FINAL_EGRESS_PORT_SET <= next_final;
        end
    end
end
// -----------------------------------------------------------------
// Buffer pool
// -----------------------------------------------------------------
wire [7:0] limit = share_ctrl[`BIT_SHARE_THIRD] ? 8'd`PORT_BUF_LIMIT :
    8'd`NUM_BUFFERS;
always @* BUF_GRANT = BUF_ALLOC && USED_BUFFERS < limit;
always @(posedge CLK or posedge RESET) begin
    if (RESET)
        USED_BUFFERS <= 8'h00;
    else if (BUF_GRANT && !(BUF_FREE && USED_BUFFERS != 8'h00))
        USED_BUFFERS <= USED_BUFFERS + 8'h01;
    else if (BUF_FREE && !BUF_GRANT && USED_BUFFERS != 8'h00)
        USED_BUFFERS <= USED_BUFFERS - 8'h01;
end
// -----------------------------------------------------------------
// Pause and flow control
// -----------------------------------------------------------------
reg [15:0] pause_q;
reg [6:0] quanta_nib;
reg xoff_state;
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        pause_q <= 16'h0000;
        quanta_nib <= 7'd0;
        xoff_state <= 1'b0;
        SEND_XOFF <= 1'b0;
        SEND_XON <= 1'b0;
    end else begin
        SEND_XOFF <= 1'b0;
        SEND_XON <= 1'b0;
        if (FRAME_END && good && FRAME_IS_PAUSE) begin
            pause_q <= FRAME_PAUSE_QUANTA;
            quanta_nib <= 7'd0;
        end else if (pause_q != 16'h0000 && tx_edge) begin
            quanta_nib <= quanta_nib + 7'd1;
            if (quanta_nib == 7'd127)
                pause_q <= pause_q - 16'h0001;
        end
        if (!xoff_state && (RESOURCE_LOW || RX_QUEUE_FULL)) begin
            xoff_state <= 1'b1;
            SEND_XOFF <= 1'b1;
        end else if (xoff_state && RESOURCE_OK && !RX_QUEUE_FULL) begin
            xoff_state <= 1'b0;
            SEND_XON <= 1'b1;
        end
    end
end
// -----------------------------------------------------------------
// Transmit MAC: gap, back-off, late collision, back-pressure
// -----------------------------------------------------------------
localparam ST_IDLE = 2'd0, ST_TX = 2'd1, ST_BACKOFF = 2'd2, ST_BP = 2'd3;
reg [1:0] state;
reg [4:0] attempts;
reg [10:0] bit_cnt;
reg [5:0] gap_nib;
reg [9:0] backoff_slots;
reg [6:0] slot_nib;
reg [15:0] lfsr;
reg [11:0] bp_cnt;
wire gap_ok = gap_nib >= 6'd`IPG_NIBBLES;
// The n-th collision draws from 0 to 2^min(n,10)-1 slots.
wire [9:0] rmask = (10'd1 << (attempts >= 5'd10 ? 4'd10 :
    attempts[3:0] + 4'd1)) - 10'd1;
always @* TX_HOLD = pause_q != 16'h0000 || !gap_ok;
always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
        state <= ST_IDLE;
        attempts <= 5'd0;
        bit_cnt <= 11'd0;
        gap_nib <= 6'd`IPG_NIBBLES;
        backoff_slots <= 10'd0;
        slot_nib <= 7'd0;
        lfsr <= 16'hACE1;
        bp_cnt <= 12'd0;
        TX_DROP <= 1'b0;
        MII_TRANSMIT_ENABLE <= 1'b0;
        MII_TXD <= 4'h0;
        MII_CARRIER_SENSE <= 1'b0;
    end else begin
        TX_DROP <= 1'b0;
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        if (MII_TRANSMIT_ENABLE || s_dv[1])
            gap_nib <= 6'd0;
        else if (tx_edge && !gap_ok)
            gap_nib <= gap_nib + 6'd1;
        case (state)
            ST_IDLE: begin
                MII_TRANSMIT_ENABLE <= 1'b0;
                MII_CARRIER_SENSE <= 1'b0;
                if (TX_START && gap_ok) begin
                    state <= ST_TX;
                    bit_cnt <= 11'd0;
                    MII_TRANSMIT_ENABLE <= 1'b1;
                    MII_CARRIER_SENSE <= 1'b1;
                end else if (xoff_state && HALF_DUPLEX && !TX_PENDING) begin
                    state <= ST_BP;
                    bp_cnt <= 12'd0;
                end
            end
            ST_TX: begin
                MII_TXD <= 4'h5;
                if (tx_edge && bit_cnt != 11'h7fc)
                    bit_cnt <= bit_cnt + 11'd4;
                if (col_now) begin
                    MII_TRANSMIT_ENABLE <= 1'b0;
                    MII_CARRIER_SENSE <= 1'b0;
                    if (bit_cnt >= 11'd`SLOT_BITS) begin
                        TX_DROP <= 1'b1;
                        attempts <= 5'd0;
                        state <= ST_IDLE;
                    end else if (attempts == 5'd`MAX_ATTEMPTS - 5'd1) begin
                        TX_DROP <= ~size_ctrl[`BIT_NO_EXC_DROP];
                        attempts <= 5'd0;
                        state <= size_ctrl[`BIT_NO_EXC_DROP] ?
                            ST_BACKOFF : ST_IDLE;
                        backoff_slots <= 10'd0;
                    end else begin
                        attempts <= attempts + 5'd1;
                        backoff_slots <= aging_ctrl[`BIT_AGGR_BACKOFF] ?
                            10'd0 : lfsr[9:0] & rmask;
                        slot_nib <= 7'd0;
                        state <= ST_BACKOFF;
                    end
                end else if (TX_DONE) begin
                    MII_TRANSMIT_ENABLE <= 1'b0;
                    MII_CARRIER_SENSE <= 1'b0;
                    attempts <= 5'd0;
                    state <= ST_IDLE;
                end
            end
            ST_BACKOFF: begin
                if (backoff_slots == 10'd0 && gap_ok) begin
                    state <= ST_TX;
                    bit_cnt <= 11'd0;
                    MII_TRANSMIT_ENABLE <= 1'b1;
                    MII_CARRIER_SENSE <= 1'b1;
                end else if (tx_edge && backoff_slots != 10'd0) begin
                    slot_nib <= slot_nib + 7'd1;
                    if (slot_nib == 7'd127)
                        backoff_slots <= backoff_slots - 10'd1;
                end
            end
            ST_BP: begin
                MII_TXD <= 4'h5;
                if (TX_PENDING || !xoff_state) begin
                    MII_TRANSMIT_ENABLE <= 1'b0;
                    MII_CARRIER_SENSE <= 1'b0;
                    state <= ST_IDLE;
                end else if (col_now) begin
                    MII_TRANSMIT_ENABLE <= 1'b1;
                    MII_CARRIER_SENSE <= 1'b1;
                    bp_cnt <= 12'd0;
                end else if (tx_edge) begin
                    bp_cnt <= (bp_cnt >= 12'd`BP_PERIOD_NIBBLES) ?
                        12'd0 : bp_cnt + 12'd1;
                    MII_TRANSMIT_ENABLE <= bp_cnt < 12'd`BP_ON_NIBBLES;
                    MII_CARRIER_SENSE <= bp_cnt < 12'd`BP_ON_NIBBLES;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end
endmodule
`default_nettype wire

/* File: core/switch_mac_defs.vh */
// Constants for the switch MAC lookup engine.
`ifndef SWITCH_MAC_DEFS_VH
`define SWITCH_MAC_DEFS_VH
`define REG_BUF_SHARE 7'h02
`define REG_AGING_BACKOFF 7'h03
`define REG_SIZE_COLL 7'h04
`define REG_STORM_HIGH 7'h06
`define REG_STORM_LOW 7'h07
`define BIT_SHARE_THIRD 0
`define BIT_AGGR_BACKOFF 0
`define BIT_AGING_EN 1
`define BIT_LONG_FRAME 1
`define BIT_NO_EXC_DROP 3
`define RST_BUF_SHARE 8'h00
`define RST_AGING_BACKOFF 8'h02
`define RST_SIZE_COLL 8'h00
`define RST_STORM 8'h63
`define TABLE_ENTRIES 1024
`define NUM_BUFFERS 250
`define BUFFER_BYTES 128
`define PORT_BUF_LIMIT 83
`define MIN_FRAME 64
`define MAX_FRAME_STD 1536
`define MAX_FRAME_LONG 1916
`define VLAN_TAG_BYTES 4
`define IPG_BITS 96
`define IPG_NIBBLES 24
`define SLOT_BITS 512
`define MAX_ATTEMPTS 16
`define AGING_SECONDS 200
`define CLK_MHZ 200
`define TICK_CYCLES (`CLK_MHZ * 1000000)
`define STORM_MS_100 67
`define STORM_MS_10 500
`define STORM_CYC_100 (`STORM_MS_100 * `CLK_MHZ * 1000)
`define STORM_CYC_10 (`STORM_MS_10 * `CLK_MHZ * 1000)
`define BP_ON_NIBBLES 2000
`define BP_OFF_NIBBLES 4
`define BP_PERIOD_NIBBLES 2004
`endif

/* File: tb/mii_partner.sv */
// Far-side MII model: free-running nibble clocks and a receive stream.
`default_nettype none
module mii_partner (
    output logic rx_clk,
    output logic tx_clk,
    output logic rx_dv,
    output logic [3:0] rxd,
    output logic rx_err,
    output logic col
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_dv = 1'b0;
        rxd = 4'h0;
        rx_err = 1'b0;
        col = 1'b0;
        rx_clk = 1'b0;
        #1.3;
        forever #80 rx_clk = ~rx_clk;
    end
    initial begin
        tx_clk = 1'b0;
        #37.7;
        forever #80 tx_clk = ~tx_clk;
    end
    // Sends preamble nibbles ending in a delimiter, then drops rx_dv and drives the inverted nibble on rxd.
    task send(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge rx_clk);
            rx_dv = 1'b1;
            rxd = (i == n - 1) ? 4'hd : 4'h5;
        end
        @(posedge rx_clk);
        rx_dv = 1'b0;
        rxd = ~rxd;
    endtask
endmodule
`default_nettype wire

/* File: tb/switch_mac_chk.sv */
// Concurrent checks on the top-level pins of the switch port engine.
`default_nettype none
module switch_mac_chk (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic FRAME_END,
    input wire logic FRAME_GOOD,
    input wire logic FRAME_IS_PAUSE,
    input wire logic FRAME_VLAN_TAGGED,
    input wire logic [10:0] FRAME_BYTES,
    input wire logic [15:0] FRAME_PAUSE_QUANTA,
    input wire logic [2:0] FIRST_STAGE_PORT_SET,
    input wire logic [2:0] FINAL_EGRESS_PORT_SET,
    input wire logic FORWARD,
    input wire logic TX_HOLD,
    input wire logic MII_TRANSMIT_ENABLE,
    input wire logic MII_TRANSMIT_ERROR,
    input wire logic [7:0] USED_BUFFERS
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_fwd_cause: assert property (FORWARD |-> $past(FRAME_END))
        else $error("forward pulse without a frame end");
    a_bad_drop: assert property (FRAME_END && !FRAME_GOOD |=> !FORWARD)
        else $error("errored frame forwarded");
    a_pause_drop: assert property (FRAME_END && FRAME_IS_PAUSE |=> !FORWARD)
        else $error("pause frame forwarded");
    a_short_drop: assert property (FRAME_END && FRAME_BYTES < 11'h040
        |=> !FORWARD) else $error("short frame forwarded");
    a_long_drop: assert property (FRAME_END && !FRAME_VLAN_TAGGED
        && FRAME_BYTES > 11'h77c |=> !FORWARD) else $error("long frame sent");
    a_pause_hold: assert property (FRAME_END && FRAME_GOOD
        && FRAME_IS_PAUSE && FRAME_PAUSE_QUANTA != 16'h0000
        |=> TX_HOLD [*2]) else $error("pause did not hold transmit");
    a_sets_stable: assert property (!$past(FRAME_END) |->
        $stable({FIRST_STAGE_PORT_SET, FINAL_EGRESS_PORT_SET}))
        else $error("port sets changed without a frame");
    a_gap_min: assert property ($fell(MII_TRANSMIT_ENABLE) |=>
        !MII_TRANSMIT_ENABLE [*8]) else $error("transmit gap too short");
    a_txerr_low: assert property (MII_TRANSMIT_ERROR == 1'b0)
        else $error("transmit error pin driven");
    a_buf_max: assert property (USED_BUFFERS <= 8'hfa)
        else $error("more buffers used than exist");
    c_forward: cover property (FORWARD);
    c_hold: cover property ($fell(TX_HOLD));
    c_transmit: cover property ($rose(MII_TRANSMIT_ENABLE));
endmodule
bind switch_mac_lookup_engine switch_mac_chk chk_i (.*);
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the switch port lookup and filter engine.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, RESET, REG_WRITE, REG_READ, MAC_MODE, SPEED_100, HALF_DUPLEX;
    logic HALF_DUPLEX_LOSSLESS_STRAP, STORM_PORT_EN, STORM_MCAST_EN;
    logic MII_RX_CLK, MII_RX_DV, MII_RX_ERR, MII_COLLISION, MII_TX_CLK;
    logic MII_TRANSMIT_ENABLE, MII_TRANSMIT_ERROR, MII_CARRIER_SENSE;
    logic FRAME_END, FRAME_GOOD, FRAME_IS_PAUSE, FRAME_IS_BCAST;
    logic FRAME_IS_MCAST, FRAME_VLAN_TAGGED, STATIC_HIT, RESOURCE_LOW;
    logic RESOURCE_OK, RX_QUEUE_FULL, BUF_ALLOC, BUF_FREE, BUF_GRANT;
    logic TX_PENDING, TX_START, TX_DONE, FORWARD, SEND_XOFF, SEND_XON;
    logic TX_HOLD, TX_DROP;
    logic [6:0] REG_ADDR;
    logic [7:0] REG_WDATA, REG_RDATA, USED_BUFFERS;
    logic [3:0] MII_RXD, MII_TXD;
    logic [10:0] FRAME_BYTES;
    logic [15:0] FRAME_PAUSE_QUANTA;
    logic [47:0] FRAME_SA, FRAME_DA;
    logic [1:0] FRAME_PORT;
    logic [2:0] STATIC_PORTS, VLAN_MEMBERS, TREE_MASK, MIRROR_PORTS;
    logic [2:0] PORT_VLAN_MASK, FIRST_STAGE_PORT_SET, FINAL_EGRESS_PORT_SET;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int k;
    logic [14:0] rv [6] = '{{7'h02, 8'h00}, {7'h03, 8'h02}, {7'h04, 8'h00},
        {7'h06, 8'h63}, {7'h07, 8'h63}, {7'h05, 8'h00}};
    logic [14:0] ft [10] = '{{3'h4, 11'h040, 1'h1}, {3'h4, 11'h03f, 1'h0},
        {3'h0, 11'h040, 1'h0}, {3'h6, 11'h040, 1'h0}, {3'h4, 11'h600, 1'h1},
        {3'h4, 11'h601, 1'h0}, {3'h5, 11'h604, 1'h1}, {3'h5, 11'h605, 1'h0},
        {3'h4, 11'h77c, 1'h1}, {3'h4, 11'h77d, 1'h0}};
    localparam logic [47:0] STA = 48'h0200_0000_000a;
    localparam logic [47:0] STB = 48'h0200_0000_00ff;
    localparam logic [47:0] STC = 48'h0200_0000_000c;
    switch_mac_lookup_engine dut (.*);
    mii_partner far (.rx_clk(MII_RX_CLK), .tx_clk(MII_TX_CLK),
        .rx_dv(MII_RX_DV), .rxd(MII_RXD), .rx_err(MII_RX_ERR),
        .col(MII_COLLISION));
    always #2.5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WRITE = 1'b1;
        @(negedge CLK);
        REG_WRITE = 1'b0;
    endtask
    task rd(input logic [6:0] a, input logic [7:0] exp);
        @(negedge CLK);
        REG_ADDR = a;
        REG_READ = 1'b1;
        @(negedge CLK);
        REG_READ = 1'b0;
        chk("register", {8'h00, exp}, {8'h00, REG_RDATA});
    endtask
    // Presents one frame descriptor and checks the forward decision.
    task frm(input logic [47:0] sa, da, input logic [1:0] p,
             input logic [2:0] f, input logic [10:0] n, input logic exp);
        @(negedge CLK);
        {FRAME_GOOD, FRAME_IS_PAUSE, FRAME_VLAN_TAGGED} = f;
        FRAME_SA = sa;
        FRAME_DA = da;
        FRAME_PORT = p;
        FRAME_BYTES = n;
        FRAME_END = 1'b1;
        @(negedge CLK);
        FRAME_END = 1'b0;
        chk("forward", {15'h0000, exp}, {15'h0000, FORWARD});
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        {CLK, REG_WRITE, REG_READ, REG_ADDR, REG_WDATA, MAC_MODE, HALF_DUPLEX,
         HALF_DUPLEX_LOSSLESS_STRAP, STORM_PORT_EN, STORM_MCAST_EN, FRAME_END,
         FRAME_GOOD, FRAME_IS_PAUSE, FRAME_IS_BCAST, FRAME_IS_MCAST,
         FRAME_VLAN_TAGGED, FRAME_BYTES, FRAME_PAUSE_QUANTA, FRAME_SA,
         FRAME_DA, FRAME_PORT, STATIC_PORTS, STATIC_HIT, MIRROR_PORTS,
         RESOURCE_LOW, RX_QUEUE_FULL, BUF_ALLOC, BUF_FREE, TX_PENDING,
         TX_START, TX_DONE} = '0;
        {VLAN_MEMBERS, TREE_MASK, PORT_VLAN_MASK} = 9'h1ff;
        {RESET, SPEED_100, RESOURCE_OK} = 3'h7;
        repeat (6) @(negedge CLK);
        RESET = 1'b0;
        repeat (2) @(negedge CLK);
        foreach (rv[i]) rd(rv[i][14:8], rv[i][7:0]);
        wr(7'h03, 8'h01);
        rd(7'h03, 8'h01);
        wr(7'h7f, 8'haa);
        rd(7'h7f, 8'h00);
        wr(7'h06, 8'h30);
        rd(7'h06, 8'h30);
        $display("test registers done");
        far.send(16);
        for (int i = 0; i < 10; i++) begin
            if (i == 8)
                wr(7'h04, 8'h02);
            frm(STA + i + 16, STB, 2'h0, ft[i][14:12], ft[i][11:1],
                ft[i][0]);
        end
        $display("test filters done");
        frm(STA, STB, 2'h1, 3'h4, 11'h040, 1'b1);
        frm(STC, STA, 2'h1, 3'h4, 11'h040, 1'b0);
        frm(STC, STA, 2'h0, 3'h4, 11'h040, 1'b1);
        chk("first set", 16'h0002, {13'h0000, FIRST_STAGE_PORT_SET});
        chk("final set", 16'h0002, {13'h0000, FINAL_EGRESS_PORT_SET});
        frm(STA, STB, 2'h2, 3'h4, 11'h040, 1'b1);
        frm(STC, STA, 2'h2, 3'h4, 11'h040, 1'b0);
        frm(STC, STA, 2'h1, 3'h4, 11'h040, 1'b1);
        $display("test learning done");
        wr(7'h02, 8'h01);
        BUF_ALLOC = 1'b1;
        repeat (90) @(negedge CLK);
        chk("grant", 16'h0000, {15'h0000, BUF_GRANT});
        chk("used", 16'h0053, {8'h00, USED_BUFFERS});
        {BUF_ALLOC, BUF_FREE} = 2'b01;
        @(negedge CLK);
        BUF_FREE = 1'b0;
        chk("freed", 16'h0052, {8'h00, USED_BUFFERS});
        {RESOURCE_OK, RESOURCE_LOW} = 2'b01;
        @(negedge CLK);
        chk("xoff", 16'h0001, {15'h0000, SEND_XOFF});
        RESOURCE_LOW = 1'b0;
        @(negedge CLK);
        chk("xoff pulse", 16'h0000, {15'h0000, SEND_XOFF});
        RESOURCE_OK = 1'b1;
        @(negedge CLK);
        chk("xon", 16'h0001, {15'h0000, SEND_XON});
        $display("test resources done");
        FRAME_PAUSE_QUANTA = 16'h0001;
        frm(STC, STB, 2'h0, 3'h6, 11'h040, 1'b0);
        chk("hold", 16'h0001, {15'h0000, TX_HOLD});
        repeat (500) @(negedge CLK);
        FRAME_PAUSE_QUANTA = 16'h0002;
        frm(STC, STB, 2'h0, 3'h6, 11'h040, 1'b0);
        // One quantum is 128 nibble clocks of 160 ns, 4096 cycles, so the
        // first timer has run out here; two quanta end 8192 cycles on.
        repeat (4000) @(negedge CLK);
        chk("hold reload", 16'h0001, {15'h0000, TX_HOLD});
        k = 0;
        while (TX_HOLD === 1'b1 && k < 4500) begin
            @(negedge CLK);
            k++;
        end
        chk("hold end", 16'h0000, {15'h0000, TX_HOLD});
        chk("hold length", 16'h0001,
            {15'h0000, k >= 4100 && k <= 4250});
        $display("test pause done");
        TX_START = 1'b1;
        @(negedge CLK);
        TX_START = 1'b0;
        chk("tx enable", 16'h0001, {15'h0000, MII_TRANSMIT_ENABLE});
        repeat (4) @(negedge CLK);
        TX_DONE = 1'b1;
        @(negedge CLK);
        TX_DONE = 1'b0;
        TX_START = 1'b1;
        @(negedge CLK);
        TX_START = 1'b0;
        chk("tx gap", 16'h0000, {15'h0000, MII_TRANSMIT_ENABLE});
        $display("test transmit done");
        end_sim();
    end
endmodule
`default_nettype wire
